/* File: pfdc_port_config.v */
// Functional notes
// - Port-1 select bits and port-2 select bits 2,1,0 (pins 4,3,0) choose I/O at 0, peripheral at 1, reset 0.
// - Port-2 select bit 6 gives shared port-1 pins to serial zero at 0, serial one at 1.
// - Port-2 select bit 5 gives shared port-1 pins to serial one at 0, timer three at 1.
// - Port-2 select bit 4 gives shared port-1 pins to timer one at 0, timer four at 1.
// - Port-2 select bit 3 gives shared port-1 pins to serial zero at 0, timer one at 1.
// - Direction bits for port 0, port 1 and port-2 pins 4:0 make a pin input at 0, output at 1.
// - All direction bits reset to zero so every pin starts as an input.
// - Port-2 direction bits 7:6 set the four-way port-0 precedence encoding.
// - Port-0 input-mode bits select pulled at 0, tristate at 1, reset zero.
// - Port-1 input mode exists for pins 7:2 only; bits 1:0 read zero and ignore writes.
// - A per-port polarity bit pulls up at 0 or down at 1; port-1 pins 0 and 1 have no pull.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "pfdc_defs.vh"

module pfdc_port_config (
  input  wire        clk,
  input  wire        nrst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  output wire [7:0]  p0_func_sel,
  output wire [7:0]  p1_func_sel,
  output wire [4:0]  p2_func_sel,
  output wire [7:0]  p0_oe,
  output wire [7:0]  p1_oe,
  output wire [4:0]  p2_oe,
  output wire [7:0]  p0_pull_en,
  output wire [7:0]  p1_pull_en,
  output wire [4:0]  p2_pull_en,
  output wire [2:0]  port_pull_polarity,
  output wire        p1_serial_pair_owner,
  output wire        p1_serial1_timer3_owner,
  output wire        p1_timer1_timer4_owner,
  output wire        p1_serial0_timer1_owner,
  output wire [1:0]  p0_shared_pin_precedence,
  output wire [4:0]  peripheral_location_control
);

  // ************************************************************
  // Registers
  // ************************************************************
  // Seven configuration registers plus two of our own, the pull polarity
  // word and the peripheral location word; each one is a single byte
  reg [7:0] p0_input_mode_q;
  reg [7:0] p1_function_select_q;
  reg [7:0] p2_select_and_priority_q;
  reg [7:0] p1_input_mode_q;
  reg [7:0] pull_polarity_q;
  reg [7:0] p0_direction_q;
  reg [7:0] p1_direction_q;
  reg [7:0] p2_direction_and_priority_q;
  reg [7:0] location_q;

  // Next values, worked out before the clock edge; outputs that are
  // decoded from several bits are registered from these
  reg [7:0] p0_input_mode_d;
  reg [7:0] p1_function_select_d;
  reg [7:0] p2_select_and_priority_d;
  reg [7:0] p1_input_mode_d;
  reg [7:0] pull_polarity_d;
  reg [7:0] p0_direction_d;
  reg [7:0] p1_direction_d;
  reg [7:0] p2_direction_and_priority_d;
  reg [7:0] location_d;

  // Bus pipeline registers
  reg        wr_pend_q;
  reg [7:0]  idx_q;
  reg [31:0] hrdata_q;

  // Registered pin outputs, so every data output except the tied-off p0_func_sel leaves a flip-flop
  reg [7:0] p0_pull_en_q;
  reg [7:0] p1_pull_en_q;
  reg [4:0] p2_pull_en_q;
  reg       p1_serial_pair_owner_q;

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  // Zero wait states; response is always OKAY. The registers are one byte
  // wide and sit in the low byte of an aligned word, so only hwdata[7:0]
  // is used and hsize is not checked: a narrower access to the low byte
  // behaves like a word access. Addresses above the map or not word
  // aligned are taken on the bus but change nothing and read zero.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire       addr_ok  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  wire       take     = hsel && hready && htrans[1];
  wire [7:0] addr_idx = haddr[9:2];

  // Address phase capture; a write lands one cycle later with its data,
  // so the index is kept until the data phase
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      idx_q     <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite && addr_ok;
      if (take) begin
        idx_q <= addr_idx;
      end
    end
  end

  // Next values: a write in its data phase replaces one register, masked
  // so that unused bits stay at zero and read back as zero
  wire [7:0] wd = hwdata[7:0];
  always @* begin
    p0_input_mode_d             = p0_input_mode_q;
    p1_function_select_d        = p1_function_select_q;
    p2_select_and_priority_d    = p2_select_and_priority_q;
    p1_input_mode_d             = p1_input_mode_q;
    pull_polarity_d             = pull_polarity_q;
    p0_direction_d              = p0_direction_q;
    p1_direction_d              = p1_direction_q;
    p2_direction_and_priority_d = p2_direction_and_priority_q;
    location_d                  = location_q;
    if (wr_pend_q) begin
      case (idx_q)
        `PFDC_IDX_P0_INPUT_MODE: p0_input_mode_d = wd;
        `PFDC_IDX_P1_FUNC_SEL:   p1_function_select_d = wd;
        `PFDC_IDX_P2_SEL_PRI:    p2_select_and_priority_d = wd & `PFDC_MASK_P2_SEL_PRI;
        `PFDC_IDX_P1_INPUT_MODE: p1_input_mode_d = wd & `PFDC_MASK_P1_INPUT_MODE;
        `PFDC_IDX_PULL_POLARITY: pull_polarity_d = wd & `PFDC_MASK_PULL_POLARITY;
        `PFDC_IDX_P0_DIR:        p0_direction_d = wd;
        `PFDC_IDX_P1_DIR:        p1_direction_d = wd;
        `PFDC_IDX_P2_DIR_PRI:    p2_direction_and_priority_d = wd & `PFDC_MASK_P2_DIR_PRI;
        `PFDC_IDX_LOCATION:      location_d = wd & `PFDC_MASK_LOCATION;
        default: begin
          // Unmapped writes are dropped, every register keeps its value
        end
      endcase
    end
  end

  // Configuration registers; the whole set moves together on one edge,
  // and every register clears to zero on reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p0_input_mode_q             <= `PFDC_RESET_VALUE;
      p1_function_select_q        <= `PFDC_RESET_VALUE;
      p2_select_and_priority_q    <= `PFDC_RESET_VALUE;
      p1_input_mode_q             <= `PFDC_RESET_VALUE;
      pull_polarity_q             <= `PFDC_RESET_VALUE;
      p0_direction_q              <= `PFDC_RESET_VALUE;
      p1_direction_q              <= `PFDC_RESET_VALUE;
      p2_direction_and_priority_q <= `PFDC_RESET_VALUE;
      location_q                  <= `PFDC_RESET_VALUE;
    end else begin
      p0_input_mode_q             <= p0_input_mode_d;
      p1_function_select_q        <= p1_function_select_d;
      p2_select_and_priority_q    <= p2_select_and_priority_d;
      p1_input_mode_q             <= p1_input_mode_d;
      pull_polarity_q             <= pull_polarity_d;
      p0_direction_q              <= p0_direction_d;
      p1_direction_q              <= p1_direction_d;
      p2_direction_and_priority_q <= p2_direction_and_priority_d;
      location_q                  <= location_d;
    end
  end

  // Read mux over the next values, so a read whose address phase meets the
  // data phase of a write to the same register already sees the new byte
  reg [7:0] rd_mux;
  always @* begin
    case (addr_idx)
      `PFDC_IDX_P0_INPUT_MODE: rd_mux = p0_input_mode_d;
      `PFDC_IDX_P1_FUNC_SEL:   rd_mux = p1_function_select_d;
      `PFDC_IDX_P2_SEL_PRI:    rd_mux = p2_select_and_priority_d;
      `PFDC_IDX_P1_INPUT_MODE: rd_mux = p1_input_mode_d;
      `PFDC_IDX_PULL_POLARITY: rd_mux = pull_polarity_d;
      `PFDC_IDX_P0_DIR:        rd_mux = p0_direction_d;
      `PFDC_IDX_P1_DIR:        rd_mux = p1_direction_d;
      `PFDC_IDX_P2_DIR_PRI:    rd_mux = p2_direction_and_priority_d;
      `PFDC_IDX_LOCATION:      rd_mux = location_d;
      default:                 rd_mux = 8'h00;
    endcase
  end

  // Read data flop, loaded at the end of the address phase and cleared
  // afterwards, so it stands for exactly the one data cycle
  wire rd_take = take && !hwrite && addr_ok;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_take) begin
      hrdata_q <= {24'h000000, rd_mux};
    end else begin
      hrdata_q <= 32'h00000000;
    end
  end

  // Port driver; the bus sees the flop directly, with no logic after it,
  // so the read data path stays short
  always @* begin
    hrdata = hrdata_q;
  end

  // ************************************************************
  // Pin configuration outputs
  // ************************************************************
  // Function select; port 0 has no select register here. Port-2 pins 2
  // and 1 have no select bit either, so their lines stay low and the pads
  // keep them on their own function.
  assign p0_func_sel = 8'h00;
  assign p1_func_sel = p1_function_select_q;
  assign p2_func_sel = {p2_select_and_priority_q[`PFDC_PORT2_SELECT_AND_PRIORITY_PIN4],
                        p2_select_and_priority_q[`PFDC_PORT2_SELECT_AND_PRIORITY_PIN3],
                        2'b00,
                        p2_select_and_priority_q[`PFDC_PORT2_SELECT_AND_PRIORITY_PIN0]};

  // Direction: 1 drives the pin. These go straight out of the registers,
  // so every pin is an input from reset until software sets its bit.
  assign p0_oe = p0_direction_q;
  assign p1_oe = p1_direction_q;
  assign p2_oe = p2_direction_and_priority_q[4:0];

  // Pull enable only for inputs in pulled mode; port-2 mode is outside this
  // block, so its pins count as pulled whenever they are inputs. Worked out
  // from the next values and registered, so pull and direction switch on
  // the same edge and a pin never pulls against its own driver.
  // Port-1 pins 1:0 have no pull, so they are treated as always tristate
  wire [7:0] p1_mode_eff = {p1_input_mode_d[7:2], 2'h3};
  wire [7:0] p0_pull_en_d;
  wire [7:0] p1_pull_en_d;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pull
      assign p0_pull_en_d[g] = !p0_direction_d[g] && !p0_input_mode_d[g];
      assign p1_pull_en_d[g] = !p1_direction_d[g] && !p1_mode_eff[g];
    end
  endgenerate

  // Pull-enable flops; out of reset every pin except port-1 pins 1:0 is a pulled input
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p0_pull_en_q <= `PFDC_RESET_P0_PULL;
      p1_pull_en_q <= `PFDC_RESET_P1_PULL;
      p2_pull_en_q <= `PFDC_RESET_P2_PULL;
    end else begin
      p0_pull_en_q <= p0_pull_en_d;
      p1_pull_en_q <= p1_pull_en_d;
      p2_pull_en_q <= ~p2_direction_and_priority_d[4:0];
    end
  end
  assign p0_pull_en = p0_pull_en_q;
  assign p1_pull_en = p1_pull_en_q;
  assign p2_pull_en = p2_pull_en_q;

  // Polarity per port: bit 0 port 0, bit 1 port 1, bit 2 port 2.
  // A 1 pulls down; it acts only on pins that are pulled inputs.
  assign port_pull_polarity = {pull_polarity_q[`PFDC_PULL_P2],
                               pull_polarity_q[`PFDC_PULL_P1],
                               pull_polarity_q[`PFDC_PULL_P0]};

  // ************************************************************
  // Shared-pin arbitration
  // ************************************************************
  // Owner is 0 for the first-named unit, 1 for the second. The three
  // timer-related owners pass their select bit straight through; the pads
  // only use them when the location control really puts both units on
  // the same pins, and software must avoid settings where three units
  // meet and the order is not conclusive.
  // The serial pair owner is gated by the overlap, so it is registered from
  // the next values to keep it a clean flop output like the others
  wire ser_same = location_d[`PFDC_LOC_SER0] == location_d[`PFDC_LOC_SER1];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p1_serial_pair_owner_q <= 1'b0;
    end else begin
      p1_serial_pair_owner_q <=
        ser_same && p2_select_and_priority_d[`PFDC_PORT2_SELECT_AND_PRIORITY_SER_PAIR];
    end
  end
  assign p1_serial_pair_owner = p1_serial_pair_owner_q;
  assign p1_serial1_timer3_owner =
    p2_select_and_priority_q[`PFDC_PORT2_SELECT_AND_PRIORITY_SER1_TMR3];
  assign p1_timer1_timer4_owner =
    p2_select_and_priority_q[`PFDC_PORT2_SELECT_AND_PRIORITY_TMR1_TMR4];
  assign p1_serial0_timer1_owner =
    p2_select_and_priority_q[`PFDC_PORT2_SELECT_AND_PRIORITY_SER0_TMR1];

  // Port-0 precedence code passed to the pad muxes: 0 serial zero first,
  // 1 serial one first, 2 timer one channels 0 and 1 before serial one,
  // 3 timer one channel 2 before serial zero
  assign p0_shared_pin_precedence =
    p2_direction_and_priority_q[`PFDC_PORT2_DIRECTION_AND_PRIORITY_PRI_HI:`PFDC_PORT2_DIRECTION_AND_PRIORITY_PRI_LO];

  // Location bits gathered for the pad muxes, timer one at the top
  assign peripheral_location_control = {location_q[`PFDC_LOC_TMR1],
                                        location_q[`PFDC_LOC_TMR3],
                                        location_q[`PFDC_LOC_TMR4],
                                        location_q[`PFDC_LOC_SER1],
                                        location_q[`PFDC_LOC_SER0]};

endmodule // pfdc_port_config

/* File: pfdc_defs.vh */
`ifndef PFDC_DEFS_VH
`define PFDC_DEFS_VH
// Register byte offsets (some printed offsets are not word aligned, so each
// printed offset is an index and the byte address is four times it)
`define PFDC_IDX_P0_INPUT_MODE   8'h8F
`define PFDC_IDX_P1_FUNC_SEL     8'hF4
`define PFDC_IDX_P2_SEL_PRI      8'hF5
`define PFDC_IDX_P1_INPUT_MODE   8'hF6
`define PFDC_IDX_PULL_POLARITY   8'hF7
`define PFDC_IDX_P0_DIR          8'hFD
`define PFDC_IDX_P1_DIR          8'hFE
`define PFDC_IDX_P2_DIR_PRI      8'hFF
`define PFDC_IDX_LOCATION        8'hF1
// Writable bit masks
`define PFDC_MASK_P2_SEL_PRI     8'h7F
`define PFDC_MASK_P1_INPUT_MODE  8'hFC
`define PFDC_MASK_P2_DIR_PRI     8'hDF
`define PFDC_MASK_PULL_POLARITY  8'hE0
`define PFDC_MASK_LOCATION       8'h73
// Reset value of every register
`define PFDC_RESET_VALUE         8'h00
// Pull enables out of reset: every pin is a pulled input, except port-1
// pins 1 and 0, which have no pull at all
`define PFDC_RESET_P0_PULL       8'hFF
`define PFDC_RESET_P1_PULL       8'hFC
`define PFDC_RESET_P2_PULL       5'h1F
// Field positions
`define PFDC_PORT2_SELECT_AND_PRIORITY_PIN4          2
`define PFDC_PORT2_SELECT_AND_PRIORITY_PIN3          1
`define PFDC_PORT2_SELECT_AND_PRIORITY_PIN0          0
`define PFDC_PORT2_SELECT_AND_PRIORITY_SER_PAIR      6
`define PFDC_PORT2_SELECT_AND_PRIORITY_SER1_TMR3     5
`define PFDC_PORT2_SELECT_AND_PRIORITY_TMR1_TMR4     4
`define PFDC_PORT2_SELECT_AND_PRIORITY_SER0_TMR1     3
`define PFDC_PORT2_DIRECTION_AND_PRIORITY_PRI_HI        7
`define PFDC_PORT2_DIRECTION_AND_PRIORITY_PRI_LO        6
`define PFDC_PULL_P0             5
`define PFDC_PULL_P1             6
`define PFDC_PULL_P2             7
`define PFDC_LOC_TMR1            6
`define PFDC_LOC_TMR3            5
`define PFDC_LOC_TMR4            4
`define PFDC_LOC_SER1            1
`define PFDC_LOC_SER0            0
// Port-0 precedence encodings
`define PFDC_P0PRI_SER0_SER1     2'h0
`define PFDC_P0PRI_SER1_SER0     2'h1
`define PFDC_P0PRI_TMR1_SER1     2'h2
`define PFDC_P0PRI_TMR1C2_SER0   2'h3
`endif

/* File: pfdc_port_config_asserts.sv */
`timescale 1ns/1ps
// ************************************************
// Bus and output relation checks
// ************************************************
module pfdc_port_config_chk (
  input wire        clk,
  input wire        nrst,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire [7:0]  p0_oe,
  input wire [7:0]  p1_oe,
  input wire [4:0]  p2_oe,
  input wire [7:0]  p0_pull_en,
  input wire [7:0]  p1_pull_en,
  input wire [4:0]  p2_pull_en,
  input wire [4:0]  p2_func_sel,
  input wire [7:0]  p1_func_sel,
  input wire        p1_serial_pair_owner,
  input wire [1:0]  p0_shared_pin_precedence,
  input wire [4:0]  peripheral_location_control
);
  reg wr_q;
  reg rd_q;
  // Data-phase flags rebuilt from the bus, so outputs can be tied to writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      rd_q <= hsel & hready & htrans[1] & ~hwrite;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_zero_wait; hreadyout && !hresp; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus wait or error seen");
  property p_idle_rd; !rd_q |-> hrdata == 32'h0; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside data phase");
  property p_pull_in; (p0_pull_en & p0_oe) == 8'h00 && p1_pull_en[1:0] == 2'h0; endproperty
  a_pull_in: assert property (p_pull_in) else $error("pull on output or bare pin");
  property p_p2_pull; p2_pull_en == ~p2_oe; endproperty
  a_p2_pull: assert property (p_p2_pull) else $error("port 2 pull not tied to input");
  property p_p2_sel; p2_func_sel[2:1] == 2'h0; endproperty
  a_p2_sel: assert property (p_p2_sel) else $error("port 2 select on missing bit");
  property p_ser_pair;
    p1_serial_pair_owner |-> peripheral_location_control[0] == peripheral_location_control[1];
  endproperty
  a_ser_pair: assert property (p_ser_pair) else $error("serial pair owner without overlap");
  property p_rst_in; $rose(nrst) |-> {p0_oe, p1_oe, p2_oe} == 21'h0; endproperty
  a_rst_in: assert property (p_rst_in) else $error("pin not input after reset");
  property p_wr_only;
    !$stable({p1_func_sel, p0_oe, p1_oe, p0_shared_pin_precedence}) |-> $past(wr_q);
  endproperty
  a_wr_only: assert property (p_wr_only) else $error("config changed without write");
endmodule // pfdc_port_config_chk

bind pfdc_port_config pfdc_port_config_chk u_chk (.clk, .nrst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .p0_oe, .p1_oe, .p2_oe, .p0_pull_en, .p1_pull_en, .p2_pull_en,
  .p2_func_sel, .p1_func_sel, .p1_serial_pair_owner, .p0_shared_pin_precedence,
  .peripheral_location_control);

/* File: tb.sv */
`timescale 1ns/1ps
`include "pfdc_defs.vh"
// ************************************************
// Register and pin configuration bench
// ************************************************
module tb;
  reg         clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rv;
  reg  [1:0]  htrans = 2'h0;
  reg  [2:0]  hsize = 3'h2;
  wire        hready, hreadyout, hresp, ow_pair, ow_s1t3, ow_t1t4, ow_s0t1;
  wire [31:0] hrdata;
  wire [7:0]  p0_oe, p1_oe, p0_pull_en, p1_pull_en, p1_func_sel;
  wire [4:0]  p2_oe, p2_pull_en, p2_func_sel, loc;
  wire [2:0]  pol;
  wire [1:0]  prec;
  integer     err_total = 0, comparisons = 0, cycles = 0, k;
  assign hready = hreadyout; // Single slave drives the bus ready
  pfdc_port_config dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .p0_func_sel(), .p1_func_sel, .p2_func_sel, .p0_oe, .p1_oe,
    .p2_oe, .p0_pull_en, .p1_pull_en, .p2_pull_en, .port_pull_polarity(pol),
    .p1_serial_pair_owner(ow_pair), .p1_serial1_timer3_owner(ow_s1t3),
    .p1_timer1_timer4_owner(ow_t1t4), .p1_serial0_timer1_owner(ow_s0t1),
    .p0_shared_pin_precedence(prec), .peripheral_location_control(loc));
  initial forever #5 clk = ~clk;
  // Hang guard, far above the 75 or so cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One single transfer; read data is taken at the edge that ends the data phase
  task bus(input w, input [9:0] a, input [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {22'h0, a}; hwrite <= w;
    @(posedge clk); while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk); while (hready !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask
  task rwchk(input [9:0] a, input [31:0] exp);
    bus(1'b1, a, 32'hFF);
    bus(1'b0, a, 32'h0);
    check(rv, exp);
  endtask
  task stop_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 check({p0_oe, p1_oe, p2_oe}, 32'h0);
    check({p0_pull_en, p1_pull_en}, 32'hFFFC);
    bus(1'b0, {`PFDC_IDX_P2_SEL_PRI, 2'h0}, 32'h0); check(rv, 32'h0);
    $display("test reset values done");
    rwchk({`PFDC_IDX_P0_INPUT_MODE, 2'h0}, 32'hFF);
    rwchk({`PFDC_IDX_P1_FUNC_SEL, 2'h0}, 32'hFF);
    rwchk({`PFDC_IDX_P2_SEL_PRI, 2'h0}, `PFDC_MASK_P2_SEL_PRI);
    rwchk({`PFDC_IDX_P1_INPUT_MODE, 2'h0}, `PFDC_MASK_P1_INPUT_MODE);
    rwchk({`PFDC_IDX_P0_DIR, 2'h0}, 32'hFF);
    rwchk({`PFDC_IDX_P1_DIR, 2'h0}, 32'hFF);
    rwchk({`PFDC_IDX_P2_DIR_PRI, 2'h0}, `PFDC_MASK_P2_DIR_PRI);
    rwchk(10'h3E0, 32'h0);
    $display("test readback masks done");
    #1 check(p2_func_sel, 32'h19);
    check({p0_oe, p1_oe, p2_oe}, 32'h1FFFFF);
    check({p0_pull_en, p1_pull_en, p2_pull_en}, 32'h0);
    check({ow_pair, ow_s1t3, ow_t1t4, ow_s0t1}, 32'hF);
    bus(1'b1, {`PFDC_IDX_P2_SEL_PRI, 2'h0}, 32'h0);
    #1 check({ow_s1t3, ow_t1t4, ow_s0t1, p2_func_sel}, 32'h0);
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'b1, {`PFDC_IDX_P2_DIR_PRI, 2'h0}, {24'h0, k[1:0], 6'h00});
      #1 check({prec, p2_oe}, {k[1:0], 5'h00});
    end
    bus(1'b1, {`PFDC_IDX_P0_DIR, 2'h0}, 32'h0F);
    bus(1'b1, {`PFDC_IDX_P0_INPUT_MODE, 2'h0}, 32'h30);
    #1 check(p0_pull_en, 32'hC0);
    bus(1'b1, {`PFDC_IDX_P2_SEL_PRI, 2'h0}, 32'h40);
    bus(1'b1, {`PFDC_IDX_LOCATION, 2'h0}, 32'h01);
    #1 check({ow_pair, loc}, 32'h01);
    bus(1'b1, {`PFDC_IDX_PULL_POLARITY, 2'h0}, 32'hE0);
    #1 check(pol, 32'h7);
    rwchk({`PFDC_IDX_PULL_POLARITY, 2'h0}, `PFDC_MASK_PULL_POLARITY);
    rwchk({`PFDC_IDX_LOCATION, 2'h0}, `PFDC_MASK_LOCATION);
    #1 check({ow_pair, loc}, 32'h3F);
    $display("test pin outputs done");
    stop_test;
  end
endmodule // tb
